// ### ascc_defs.vh
// constants of the asynchronous serial controller core
// included by the core only, not by its buffer; definitions only
`ifndef ASCC_DEFS_VH
`define ASCC_DEFS_VH
// register offsets on the three-bit host address
`define ASCC_OFS_DATA 3'h0
`define ASCC_OFS_IEN 3'h1
`define ASCC_OFS_IID 3'h2
`define ASCC_OFS_LFC 3'h3
`define ASCC_OFS_MLC 3'h4
`define ASCC_OFS_LST 3'h5
`define ASCC_OFS_MST 3'h6
// line format control fields
`define ASCC_LFC_LEN 1:0
`define ASCC_LFC_STOP 2
`define ASCC_LFC_PAR 3
`define ASCC_LFC_EVEN 4
`define ASCC_LFC_STICK 5
`define ASCC_LFC_BREAK 6
`define ASCC_LFC_DAB 7
// modem line control fields
`define ASCC_MLC_LOOP 4
// interrupt enable fields
`define ASCC_IEN_RDA 0
`define ASCC_IEN_THE 1
`define ASCC_IEN_RLS 2
`define ASCC_IEN_MST 3
// identification codes on bits 3:0
`define ASCC_IID_NONE 4'h1
`define ASCC_IID_RLS 4'h6
`define ASCC_IID_RDA 4'h4
`define ASCC_IID_THE 4'h2
`define ASCC_IID_MST 4'h0
// reset values
`define ASCC_RST_REG 8'h00
`define ASCC_RST_DIV 16'h0001
// 16x timing: ticks per bit, half bit, one and a half bits
`define ASCC_TICKS_BIT 5'h10
`define ASCC_TICKS_HALF 5'h08
`define ASCC_TICKS_3HALF 6'h18
`define ASCC_TICKS_2BIT 6'h20
`define ASCC_LEN_BASE 3'h4
`endif

// ### ascc_fifo.v
// small first-in first-out buffer with registered read data
// single clock, synchronous reset; both sides use valid and ready
`timescale 1ns/1ps
`default_nettype none
module ascc_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // filling side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // draining side
  output reg out_valid_q,
  output reg [WIDTH-1:0] out_data_q,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid_q & out_ready;
  wire [AW-1:0] rd_d = pop ? rd_q + 1'b1 : rd_q;
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready = (cnt_q < DEPTH);
  // storage and pointers; head word is bypassed when written into an empty buffer
  always @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    if (reset) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_valid_q <= (cnt_d != {(AW+1){1'b0}});
      out_data_q <= (push && wr_q == rd_d) ? in_data : mem_q[rd_d];
    end
  end
endmodule // ascc_fifo
`default_nettype wire

// ### ascc_core.v
// asynchronous serial controller core: registers, receiver, transmitter,
// prioritized interrupts, modem control and local loopback
// assumes a synchronous host strobe bus on sys_clk; serial and modem pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "ascc_defs.vh"
// How it works
// - characters go out and come in least significant bit first
// - receiver samples at 16x bit rate, stores bits by index, loads receive buffer
// - receive buffer load raises enabled data interrupt; buffer read clears it
// - holding word moves to idle shift register, then is serialized out
// - empty holding register raises enabled interrupt; writing it clears
// - identification read clears holding-empty interrupt only when it is reported
// - enable bits 0-3 gate four interrupt sources; bits 4-7 read zero
// - priority: line status, received data, holding empty, modem status
// - identification bit 0 low when pending; interrupt output follows pending
// - bits 2:1 code the top source; bits 3-7 read zero
// - overrun, parity, framing or break raise line status; status read clears
// - modem line changes raise modem interrupt, ring only when it ends; modem status read clears
// - format bits 1:0 select five to eight data bits
// - stop bit: one, or 1.5 for five bits, else two; receiver checks one
// - parity enable inserts parity before stop and enables checking
// - bit 4 selects even parity, clear selects odd
// - stick parity sends and checks fixed zero or one
// - break bit forces serial output low outside loopback, transmitter keeps running
// - divisor access bit steers offsets 0 and 1 to divisor latches
// - modem control bits 0-3 drive four pins inverted
// - loopback holds output high, ignores input, loops shifter to receiver
// - loopback ignores modem pins, loops controls, outputs held high
// - in loopback interrupts still work, modem events come from controls
// - offset 0 reads buffer, writes holding; offset 1 is interrupt enable
// - reset clears enable, format and modem control; identification reads 01
// - in loopback modem state bits follow the control bits
module ascc_core #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // host register bus
  input wire bus_cs,
  input wire bus_rd,
  input wire bus_wr,
  input wire [2:0] bus_addr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_q,
  // serial line
  input wire serial_input_pin,
  output reg serial_output_pin_q,
  // modem inputs, active low
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  // modem outputs, active low
  output reg dtr_n_q,
  output reg rts_n_q,
  output reg out1_n_q,
  output reg out2_n_q,
  // interrupt request, active high
  output reg interrupt_output_q
);
  localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3, RX_STOP = 3'h4, RX_WAIT = 3'h5;
  localparam TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3, TX_STOP = 3'h4;
  reg [7:0] interrupt_enable_q, line_format_control_q, modem_line_control_q;
  reg [15:0] divisor_q, baud_cnt_q;
  reg baud_tick_q;
  reg [7:0] receive_buffer_q, transmit_holding_q;
  reg holding_full_q, holding_int_q;
  reg data_ready_q, overrun_q, parity_err_q, framing_err_q, break_q;
  reg [3:0] modem_delta_q, modem_prev_q;
  reg [4:0] sync1_q, sync2_q, sync3_q, pin_q;
  // receiver state
  reg [2:0] rx_state_q;
  reg [4:0] rx_tick_q;
  reg [2:0] rx_idx_q;
  reg [7:0] rx_data_q;
  reg rx_par_q, rx_push_q, rx_stop_ok_q, rx_par_ok_q;
  // transmitter state
  reg [2:0] tx_state_q;
  reg [5:0] tx_tick_q;
  reg [2:0] tx_idx_q;
  reg [7:0] tx_data_q;
  reg tx_line_q;
  // decoded host accesses
  wire dab = line_format_control_q[`ASCC_LFC_DAB];
  wire loop = modem_line_control_q[`ASCC_MLC_LOOP];
  wire wr = bus_cs & bus_wr;
  wire rd = bus_cs & bus_rd;
  wire wr_holding = wr & ~dab & (bus_addr == `ASCC_OFS_DATA);
  wire rd_buffer = rd & ~dab & (bus_addr == `ASCC_OFS_DATA);
  wire wr_enable = wr & ~dab & (bus_addr == `ASCC_OFS_IEN);
  wire wr_div_lo = wr & dab & (bus_addr == `ASCC_OFS_DATA);
  wire wr_div_hi = wr & dab & (bus_addr == `ASCC_OFS_IEN);
  wire rd_ident = rd & (bus_addr == `ASCC_OFS_IID);
  wire rd_lstat = rd & (bus_addr == `ASCC_OFS_LST);
  wire rd_mstat = rd & (bus_addr == `ASCC_OFS_MST);
  // format decode
  wire [2:0] last_idx = `ASCC_LEN_BASE + {1'b0, line_format_control_q[`ASCC_LFC_LEN]};
  wire par_on = line_format_control_q[`ASCC_LFC_PAR];
  wire par_even = line_format_control_q[`ASCC_LFC_EVEN];
  wire par_stick = line_format_control_q[`ASCC_LFC_STICK];
  wire [7:0] len_mask = 8'hff >> (3'h7 - last_idx);

  // pin synchronisers: three flops, a change counts when the last two agree
  genvar gi;
  wire [4:0] pin_raw = {dcd_n, ri_n, dsr_n, cts_n, serial_input_pin};
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (reset) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
          pin_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            pin_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  // modem state {dcd, ri, dsr, cts} active high, from pins or looped controls
  wire [3:0] modem_state = loop ? {modem_line_control_q[3], modem_line_control_q[2], modem_line_control_q[0],
                                   modem_line_control_q[1]} : ~pin_q[4:1];
  wire rx_line = loop ? tx_line_q : pin_q[0];

  // 16x baud generator; a divisor write reloads the counter
  always @(posedge sys_clk) begin
    if (reset) begin
      divisor_q <= `ASCC_RST_DIV;
      baud_cnt_q <= `ASCC_RST_DIV;
      baud_tick_q <= 1'b0;
    end else begin
      if (wr_div_lo) begin
        divisor_q[7:0] <= bus_wdata;
      end
      if (wr_div_hi) begin
        divisor_q[15:8] <= bus_wdata;
      end
      baud_tick_q <= 1'b0;
      if (wr_div_lo | wr_div_hi) begin
        baud_cnt_q <= divisor_q;
      end else if (baud_cnt_q <= 16'h0001) begin
        baud_cnt_q <= divisor_q;
        baud_tick_q <= 1'b1;
      end else begin
        baud_cnt_q <= baud_cnt_q - 16'h0001;
      end
    end
  end

  // expected parity for both directions
  wire exp_rx_par = par_stick ? ~par_even : (par_even ? ^rx_data_q : ~^rx_data_q);
  wire [7:0] tx_bits = tx_data_q & len_mask;
  wire exp_tx_par = par_stick ? ~par_even : (par_even ? ^tx_bits : ~^tx_bits);

  // receiver: mid-bit sampling at 16x, data bits stored by index
  always @(posedge sys_clk) begin
    if (reset) begin
      rx_state_q <= RX_IDLE;
      rx_tick_q <= 5'h00;
      rx_idx_q <= 3'h0;
      rx_data_q <= 8'h00;
      rx_par_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_stop_ok_q <= 1'b1;
      rx_par_ok_q <= 1'b1;
    end else begin
      rx_push_q <= 1'b0;
      if (baud_tick_q) begin
        rx_tick_q <= rx_tick_q + 5'h01;
        case (rx_state_q)
          RX_IDLE: begin
            rx_tick_q <= 5'h00;
            if (!rx_line) begin
              rx_state_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_tick_q == `ASCC_TICKS_HALF - 5'h01) begin
              rx_tick_q <= 5'h00;
              rx_idx_q <= 3'h0;
              rx_data_q <= 8'h00;
              rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_tick_q == `ASCC_TICKS_BIT - 5'h01) begin
              rx_tick_q <= 5'h00;
              rx_data_q[rx_idx_q] <= rx_line;
              rx_idx_q <= rx_idx_q + 3'h1;
              if (rx_idx_q == last_idx) begin
                rx_state_q <= par_on ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            if (rx_tick_q == `ASCC_TICKS_BIT - 5'h01) begin
              rx_tick_q <= 5'h00;
              rx_par_q <= rx_line;
              rx_state_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_tick_q == `ASCC_TICKS_BIT - 5'h01) begin
              rx_tick_q <= 5'h00;
              rx_stop_ok_q <= rx_line;
              rx_par_ok_q <= ~par_on | (rx_par_q == exp_rx_par);
              rx_push_q <= 1'b1;
              rx_state_q <= rx_line ? RX_IDLE : RX_WAIT;
            end
          end
          RX_WAIT: begin
            if (rx_line) begin
              rx_state_q <= RX_IDLE;
            end
          end
          default: begin
            rx_state_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // receive buffer queue: {break, framing, parity, data}
  wire rx_is_break = ~rx_stop_ok_q & (rx_data_q == 8'h00) & (~par_on | ~rx_par_q);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [10:0] fifo_out_data;
  ascc_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(rx_push_q),
    .in_data({rx_is_break, ~rx_stop_ok_q, ~rx_par_ok_q, rx_data_q}),
    .in_ready(fifo_in_ready),
    .out_valid_q(fifo_out_valid),
    .out_data_q(fifo_out_data),
    .out_ready(~data_ready_q)
  );
  wire buf_load = fifo_out_valid & ~data_ready_q;

  // receive buffer and line status flags; a setting event wins over a read
  always @(posedge sys_clk) begin
    if (reset) begin
      receive_buffer_q <= 8'h00;
      data_ready_q <= 1'b0;
      overrun_q <= 1'b0;
      parity_err_q <= 1'b0;
      framing_err_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      if (buf_load) begin
        receive_buffer_q <= fifo_out_data[7:0];
      end
      data_ready_q <= buf_load | (data_ready_q & ~rd_buffer);
      overrun_q <= (rx_push_q & ~fifo_in_ready) | (overrun_q & ~rd_lstat);
      parity_err_q <= (buf_load & fifo_out_data[8]) | (parity_err_q & ~rd_lstat);
      framing_err_q <= (buf_load & fifo_out_data[9]) | (framing_err_q & ~rd_lstat);
      break_q <= (buf_load & fifo_out_data[10]) | (break_q & ~rd_lstat);
    end
  end

  // transmitter: holding register feeds the shifter only when it is idle
  wire tx_load = holding_full_q & (tx_state_q == TX_IDLE);
  wire [5:0] stop_ticks = ~line_format_control_q[`ASCC_LFC_STOP] ? {1'b0, `ASCC_TICKS_BIT} :
                          (line_format_control_q[`ASCC_LFC_LEN] == 2'b00) ? `ASCC_TICKS_3HALF : `ASCC_TICKS_2BIT;
  always @(posedge sys_clk) begin
    if (reset) begin
      transmit_holding_q <= 8'h00;
      holding_full_q <= 1'b0;
      tx_state_q <= TX_IDLE;
      tx_tick_q <= 6'h00;
      tx_idx_q <= 3'h0;
      tx_data_q <= 8'h00;
      tx_line_q <= 1'b1;
    end else begin
      if (wr_holding) begin
        transmit_holding_q <= bus_wdata;
      end
      holding_full_q <= wr_holding | (holding_full_q & ~tx_load);
      if (tx_load) begin
        tx_data_q <= transmit_holding_q;
        tx_state_q <= TX_START;
        tx_tick_q <= 6'h00;
        tx_line_q <= 1'b0;
      end else if (baud_tick_q && tx_state_q != TX_IDLE) begin
        tx_tick_q <= tx_tick_q + 6'h01;
        case (tx_state_q)
          TX_START, TX_DATA, TX_PAR: begin
            if (tx_tick_q == {1'b0, `ASCC_TICKS_BIT} - 6'h01) begin
              tx_tick_q <= 6'h00;
              if (tx_state_q == TX_START) begin
                tx_idx_q <= 3'h0;
                tx_line_q <= tx_data_q[0];
                tx_state_q <= TX_DATA;
              end else if (tx_state_q == TX_DATA && tx_idx_q != last_idx) begin
                tx_idx_q <= tx_idx_q + 3'h1;
                tx_line_q <= tx_data_q[tx_idx_q + 3'h1];
              end else if (tx_state_q == TX_DATA && par_on) begin
                tx_line_q <= exp_tx_par;
                tx_state_q <= TX_PAR;
              end else begin
                tx_line_q <= 1'b1;
                tx_state_q <= TX_STOP;
              end
            end
          end
          TX_STOP: begin
            if (tx_tick_q == stop_ticks - 6'h01) begin
              tx_tick_q <= 6'h00;
              tx_state_q <= TX_IDLE;
            end
          end
          default: begin
            tx_state_q <= TX_IDLE;
            tx_line_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // interrupt sources and identification
  wire pend_rls = interrupt_enable_q[`ASCC_IEN_RLS] & (overrun_q | parity_err_q | framing_err_q | break_q);
  wire pend_rda = interrupt_enable_q[`ASCC_IEN_RDA] & data_ready_q;
  wire pend_the = interrupt_enable_q[`ASCC_IEN_THE] & holding_int_q;
  wire pend_mst = interrupt_enable_q[`ASCC_IEN_MST] & (modem_delta_q != 4'h0);
  reg [3:0] ident_code;
  always @* begin
    ident_code = `ASCC_IID_NONE;
    if (pend_rls) begin
      ident_code = `ASCC_IID_RLS;
    end else if (pend_rda) begin
      ident_code = `ASCC_IID_RDA;
    end else if (pend_the) begin
      ident_code = `ASCC_IID_THE;
    end else if (pend_mst) begin
      ident_code = `ASCC_IID_MST;
    end
  end

  // holding-empty interrupt latch and modem change flags; events win over clears
  wire the_set = tx_load | (wr_enable & bus_wdata[`ASCC_IEN_THE] & ~interrupt_enable_q[`ASCC_IEN_THE] &
                            ~holding_full_q);
  wire the_clr = wr_holding | (rd_ident & (ident_code == `ASCC_IID_THE));
  wire [3:0] modem_chg = (modem_state ^ modem_prev_q) & {1'b1, ~modem_state[2], 2'b11};
  always @(posedge sys_clk) begin
    if (reset) begin
      holding_int_q <= 1'b0;
      modem_delta_q <= 4'h0;
      modem_prev_q <= 4'h0;
    end else begin
      holding_int_q <= the_set | (holding_int_q & ~the_clr);
      modem_prev_q <= modem_state;
      modem_delta_q <= modem_chg | (modem_delta_q & {4{~rd_mstat}});
    end
  end

  // control registers written by the host
  always @(posedge sys_clk) begin
    if (reset) begin
      interrupt_enable_q <= `ASCC_RST_REG;
      line_format_control_q <= `ASCC_RST_REG;
      modem_line_control_q <= `ASCC_RST_REG;
    end else begin
      if (wr_enable) begin
        interrupt_enable_q <= {4'h0, bus_wdata[3:0]};
      end
      if (wr && bus_addr == `ASCC_OFS_LFC) begin
        line_format_control_q <= bus_wdata;
      end
      if (wr && bus_addr == `ASCC_OFS_MLC) begin
        modem_line_control_q <= {3'h0, bus_wdata[4:0]};
      end
    end
  end

  // read data, registered on the read strobe
  always @(posedge sys_clk) begin
    if (reset) begin
      bus_rdata_q <= 8'h00;
    end else if (rd) begin
      case (bus_addr)
        `ASCC_OFS_DATA: bus_rdata_q <= dab ? divisor_q[7:0] : (receive_buffer_q & len_mask);
        `ASCC_OFS_IEN: bus_rdata_q <= dab ? divisor_q[15:8] : interrupt_enable_q;
        `ASCC_OFS_IID: bus_rdata_q <= {4'h0, ident_code};
        `ASCC_OFS_LFC: bus_rdata_q <= line_format_control_q;
        `ASCC_OFS_MLC: bus_rdata_q <= modem_line_control_q;
        `ASCC_OFS_LST: bus_rdata_q <= {1'b0, ~holding_full_q & (tx_state_q == TX_IDLE), ~holding_full_q, break_q,
                                       framing_err_q, parity_err_q, overrun_q, data_ready_q};
        `ASCC_OFS_MST: bus_rdata_q <= {modem_state, modem_delta_q};
        default: bus_rdata_q <= 8'h00;
      endcase
    end
  end

  // pins: break forces output low outside loopback; loopback holds output and modem pins high
  always @(posedge sys_clk) begin
    if (reset) begin
      serial_output_pin_q <= 1'b1;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
      out1_n_q <= 1'b1;
      out2_n_q <= 1'b1;
      interrupt_output_q <= 1'b0;
    end else begin
      serial_output_pin_q <= loop | (tx_line_q & ~line_format_control_q[`ASCC_LFC_BREAK]);
      dtr_n_q <= loop | ~modem_line_control_q[0];
      rts_n_q <= loop | ~modem_line_control_q[1];
      out1_n_q <= loop | ~modem_line_control_q[2];
      out2_n_q <= loop | ~modem_line_control_q[3];
      interrupt_output_q <= pend_rls | pend_rda | pend_the | pend_mst;
    end
  end
endmodule // ascc_core
`default_nettype wire

// ### ascc_core_asserts.sv
// port checker for the serial controller core
// bound to ascc_core by the bench; shadows the control registers
`timescale 1ns/1ps
`default_nettype none
module ascc_core_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // host bus
  input wire logic bus_cs,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata_q,
  // pins driven by the core
  input wire logic serial_output_pin_q,
  input wire logic dtr_n_q,
  input wire logic rts_n_q,
  input wire logic out1_n_q,
  input wire logic out2_n_q,
  input wire logic interrupt_output_q
);
  logic [7:0] lfc_q;
  logic [4:0] mlc_q;
  logic [3:0] ien_q;
  wire rd_on = bus_cs && bus_rd;
  wire [3:0] mo = {mlc_q[0], mlc_q[1], mlc_q[2], mlc_q[3]};
  wire [3:0] mpins = {dtr_n_q, rts_n_q, out1_n_q, out2_n_q};
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // shadow copies of format, modem control and enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lfc_q <= 8'h00;
      mlc_q <= 5'h00;
      ien_q <= 4'h0;
    end else if (bus_cs && bus_wr) begin
      lfc_q <= (bus_addr == 3'h3) ? bus_wdata : lfc_q;
      mlc_q <= (bus_addr == 3'h4) ? bus_wdata[4:0] : mlc_q;
      ien_q <= (bus_addr == 3'h1 && !lfc_q[7]) ? bus_wdata[3:0] : ien_q;
    end
  end
  // a start bit lasts at least half a bit at divisor one
  sequence s_start_low;
    !serial_output_pin_q [*8];
  endsequence
  a_reset_outputs: assert property ($fell(reset) |-> serial_output_pin_q && !interrupt_output_q
    && bus_rdata_q == 8'h00 && mpins == 4'hf) else $error("outputs not at reset level");
  a_ien_upper_zero: assert property (rd_on && bus_addr == 3'h1 && !lfc_q[7]
    |=> bus_rdata_q[7:4] == 4'h0) else $error("enable upper bits set");
  a_iid_code_form: assert property (rd_on && bus_addr == 3'h2 |=> bus_rdata_q[7:3] == 5'h00
    && (!bus_rdata_q[0] || bus_rdata_q[2:1] == 2'b00)) else $error("bad ident form");
  a_irq_all_off: assert property (ien_q == 4'h0 && $past(ien_q) == 4'h0
    |=> !interrupt_output_q) else $error("interrupt with all disabled");
  a_break_low: assert property (lfc_q[6] && !mlc_q[4] |=> !serial_output_pin_q)
    else $error("break not driving low");
  a_loop_pins_high: assert property (mlc_q[4] && !lfc_q[6] |=> serial_output_pin_q
    && mpins == 4'hf) else $error("loopback pins not high");
  a_modem_outs: assert property (!mlc_q[4] |=> mpins == ~$past(mo))
    else $error("modem outputs wrong");
  a_start_bit: assert property ($fell(serial_output_pin_q) && !lfc_q[6] |-> s_start_low)
    else $error("start bit too short");
  a_lfc_readback: assert property (rd_on && bus_addr == 3'h3 |=> bus_rdata_q == lfc_q)
    else $error("format readback wrong");
endmodule // ascc_core_asserts
`default_nettype wire

// ### ascc_peer.sv
// serial peer: sends and captures characters at 16 clocks a bit
// assumes divisor one, so one bit is 16 sys_clk cycles
`timescale 1ns/1ps
`default_nettype none
module ascc_peer (
  // timing reference
  input wire logic sys_clk,
  // line from the core
  input wire logic line_in,
  // line to the core
  output logic line_out
);
  int t_fall;
  initial line_out = 1'b1;
  // start, n bits lsb first, one stop
  task automatic send(input logic [8:0] w, input int n);
    line_out = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    for (int i = 0; i < n; i++) begin
      line_out = w[i];
      repeat (16) @(posedge sys_clk);
      #1;
    end
    line_out = 1'b1;
    repeat (16) @(posedge sys_clk);
    #1;
  endtask
  // capture n bits at mid bit; returns in the last bit
  task automatic recv(input int n, output logic [8:0] w);
    w = 9'h000;
    @(negedge line_in);
    t_fall = int'($time);
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge sys_clk);
      #1 w[i] = line_in;
    end
  endtask
endmodule // ascc_peer
`default_nettype wire

// ### async_serial_controller_core_tb.sv
// self-checking bench for the serial controller core
// strobe bus tasks, modem pins and a serial peer at divisor one
`timescale 1ns/1ps
`default_nettype none
module async_serial_controller_core_tb;
  logic sys_clk, reset = 1'b1;
  logic bus_cs = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00, mk;
  logic cts_n = 1'b1, dsr_n = 1'b1, ri_n = 1'b1, dcd_n = 1'b1;
  wire [7:0] rdata;
  wire ser_in, ser_out, dtr_n, rts_n, out1_n, out2_n, irq;
  int n_mismatch = 0, samples_checked = 0, t1, nb, nw, st;
  logic [8:0] w1, w2;
  logic [7:0] lfc_tab [6] = '{8'h03, 8'h00, 8'h1a, 8'h0d, 8'h3b, 8'h2c};
  ascc_core u_dut (.sys_clk(sys_clk), .reset(reset), .bus_cs(bus_cs), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(rdata), .serial_input_pin(ser_in),
    .serial_output_pin_q(ser_out), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .dtr_n_q(dtr_n),
    .rts_n_q(rts_n), .out1_n_q(out1_n), .out2_n_q(out2_n), .interrupt_output_q(irq));
  ascc_peer u_peer (.sys_clk(sys_clk), .line_in(ser_out), .line_out(ser_in));
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one-cycle strobes, released after the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cyc(1);
    {bus_cs, bus_wr, bus_addr, bus_wdata} = {2'b11, a, d};
    cyc(1);
    {bus_cs, bus_wr} = 2'b00;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    cyc(1);
    {bus_cs, bus_rd, bus_addr} = {2'b11, a};
    cyc(1);
    {bus_cs, bus_rd} = 2'b00;
    chk(rdata & m, e & m);
  endtask
  // expected character bits with parity above the data
  function automatic logic [8:0] frame(input logic [7:0] d, input logic [7:0] c);
    logic [7:0] m;
    logic p;
    m = d & (8'hff >> (2'd3 - c[1:0]));
    p = c[5] ? ~c[4] : (c[4] ? ^m : ~^m);
    frame = c[3] ? {1'b0, m} | ({8'h00, p} << (c[1:0] + 4'd5)) : {1'b0, m};
  endfunction
  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    cyc(6);
    reset = 1'b0;
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    rd(3'h3, 8'h00);
    rd(3'h4, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h0f);
    wr(3'h1, 8'h00);
    foreach (lfc_tab[i]) begin
      wr(3'h3, lfc_tab[i]);
      nb = int'(lfc_tab[i][1:0]) + 5;
      nw = nb + int'(lfc_tab[i][3]);
      mk = 8'hff >> (2'd3 - lfc_tab[i][1:0]);
      fork
        begin
          u_peer.recv(nw, w1);
          t1 = u_peer.t_fall;
          u_peer.recv(nw, w2);
        end
        begin
          wr(3'h0, 8'hb5);
          cyc(4);
          wr(3'h0, 8'h4a);
        end
      join
      chk(w1, frame(8'hb5, lfc_tab[i]));
      chk(w2, frame(8'h4a, lfc_tab[i]));
      st = lfc_tab[i][2] ? (nb == 5 ? 24 : 32) : 16;
      // the shifter reloads from the holding register one clock after its last stop tick
      chk(u_peer.t_fall - t1, 10 * (16 * (1 + nw) + st + 1));
      u_peer.send(frame(8'h9e, lfc_tab[i]), nw);
      cyc(8);
      rd(3'h0, 8'h9e & mk);
    end
    wr(3'h3, 8'h1b);
    wr(3'h1, 8'h02);
    cyc(2);
    chk(irq, 1'b1);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    wr(3'h1, 8'h05);
    u_peer.send(frame(8'h3c, 8'h1b) ^ 9'h100, 9);
    cyc(8);
    rd(3'h2, 8'h06);
    rd(3'h5, 8'h65);
    rd(3'h2, 8'h04);
    rd(3'h0, 8'h3c);
    rd(3'h2, 8'h01);
    cyc(1);
    chk(irq, 1'b0);
    wr(3'h3, 8'h43);
    cyc(2);
    chk(ser_out, 1'b0);
    wr(3'h3, 8'h03);
    cyc(2);
    chk(ser_out, 1'b1);
    wr(3'h4, 8'h1f);
    wr(3'h0, 8'ha5);
    cyc(200);
    chk({ser_out, dtr_n, rts_n, out1_n, out2_n}, 5'h1f);
    rd(3'h0, 8'ha5);
    rd(3'h6, 8'hf0, 8'hf0);
    wr(3'h4, 8'h12);
    wr(3'h1, 8'h08);
    rd(3'h6, 8'h10, 8'hf0);
    wr(3'h4, 8'h10);
    cyc(4);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'h01);
    rd(3'h2, 8'h01);
    wr(3'h4, 8'h05);
    cyc(8);
    chk({dtr_n, rts_n, out1_n, out2_n}, 4'h5);
    rd(3'h6, 8'h00, 8'hf0);
    cts_n = 1'b0;
    cyc(8);
    rd(3'h2, 8'h00);
    rd(3'h6, 8'h11);
    rd(3'h2, 8'h01);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'h02);
    rd(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    rd(3'h1, 8'h08);
    results();
  end
endmodule // async_serial_controller_core_tb
bind ascc_core ascc_core_asserts u_chk (.sys_clk(sys_clk), .reset(reset), .bus_cs(bus_cs), .bus_rd(bus_rd),
  .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
  .serial_output_pin_q(serial_output_pin_q), .dtr_n_q(dtr_n_q), .rts_n_q(rts_n_q), .out1_n_q(out1_n_q),
  .out2_n_q(out2_n_q), .interrupt_output_q(interrupt_output_q));
`default_nettype wire
